// ==== src/ufd_pkg.sv ====
// Register map, field positions and timing of the endpoint housekeeping block
package ufd_pkg;
    // Register byte offsets
    localparam logic [3:0] UFD_OFF_FLUSH       = 4'h0;
    localparam logic [3:0] UFD_OFF_HALT        = 4'h4;
    localparam logic [3:0] UFD_OFF_DMA         = 4'h8;
    localparam logic [3:0] UFD_OFF_CTRL        = 4'hc;

    // fifo_flush_trigger fields
    localparam int UFD_FLUSH_BULK_IN_TWO_BIT   = 5;
    localparam int UFD_FLUSH_BULK_OUT_ONE_BIT  = 4;
    localparam int UFD_FLUSH_CONTROL_OUT_BIT   = 1;
    localparam int UFD_FLUSH_CONTROL_IN_BIT    = 0;

    // endpoint_stall_control fields
    localparam int UFD_HALT_WIDTH              = 4;
    localparam int UFD_HALT_ZERO_BIT           = 0;

    // endpoint_dma_request_enable fields
    localparam int UFD_DMA_BULK_OUT_ONE_BIT    = 0;
    localparam int UFD_DMA_BULK_IN_TWO_BIT     = 1;

    // Control word fields
    localparam int UFD_CTRL_AUTO_HALT_CLEAR_BIT = 1;

    // Reset values
    localparam logic [3:0] UFD_HALT_RESET      = 4'h0;
    localparam logic [1:0] UFD_DMA_RESET       = 2'h0;
    localparam logic       UFD_AUTO_RESET      = 1'b0;

    // Length of one internal FIFO clear, in cycles
    localparam int         UFD_FLUSH_CYCLES    = 3;
    localparam logic [1:0] UFD_FLUSH_LOAD      = 2'(UFD_FLUSH_CYCLES - 1);

    // AXI responses
    localparam logic [1:0] UFD_RESP_OKAY       = 2'h0;
    localparam logic [1:0] UFD_RESP_SLVERR     = 2'h2;

    // Which flush timers exist, indexed by trigger order
    localparam int UFD_NUM_FLUSH               = 4;
endpackage : ufd_pkg

// ==== src/ufd_flush_timer.sv ====
// One-shot FIFO clear sequencer: a start gives one clear pulse and a busy window
`timescale 1ns/1ps
module ufd_flush_timer
    import ufd_pkg::*;
(
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Trigger
    input  wire logic start,
    // Results
    output logic      flush_pulse,
    output logic      busy
);
    logic [1:0] remaining;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flush_pulse <= 1'b0;
        end else begin
            flush_pulse <= start;
        end
    end

    // A new start during a clear simply restarts the window
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy      <= 1'b0;
            remaining <= 2'h0;
        end else if (start) begin
            busy      <= 1'b1;
            remaining <= UFD_FLUSH_LOAD;
        end else if (remaining != 2'h0) begin
            remaining <= remaining - 2'h1;
        end else begin
            busy      <= 1'b0;
        end
    end
endmodule : ufd_flush_timer

// ==== src/ufd_dma_request.sv ====
// DMA request generation for the bulk OUT one and bulk IN two data registers
`timescale 1ns/1ps
module ufd_dma_request
    import ufd_pkg::*;
(
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Enables from software
    input  wire logic [1:0] dma_enable,
    // FIFO side state
    input  wire logic [1:0] bulk_out_one_side_valid,
    input  wire logic [1:0] bulk_in_two_side_full,
    // Requests to the dma_controller
    output logic            dma_req_bulk_out_one,
    output logic            dma_req_bulk_in_two
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dma_req_bulk_out_one <= 1'b0;
            dma_req_bulk_in_two  <= 1'b0;
        end else begin
            dma_req_bulk_out_one <= dma_enable[UFD_DMA_BULK_OUT_ONE_BIT]
                                    && (|bulk_out_one_side_valid);
            dma_req_bulk_in_two  <= dma_enable[UFD_DMA_BULK_IN_TWO_BIT]
                                    && !(&bulk_in_two_side_full);
        end
    end
endmodule : ufd_dma_request

// ==== src/ufd_endpoint_housekeeping.sv ====
// Endpoint flush, halt and DMA request control behind an AXI4-Lite slave
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// How it works
// - Writing 1 to flush bit 5 clears the bulk IN two FIFO.
// - Bit 5 reads busy during that clear, then drops by itself.
// - Writing 1 to flush bit 4 clears the bulk OUT one FIFO.
// - Writing 1 to flush bit 1 clears the control OUT FIFO.
// - Writing 1 to flush bit 0 clears the control IN FIFO.
// - Bit 0 reads busy during that clear; software waits four cycles after.
// - A set halt bit makes the endpoint answer STALL from the next transfer.
// - Halt bits 3..0 for endpoints three..zero, reset 0, upper bits zero.
// - A decoded 8-byte control request clears the endpoint zero halt.
// - Writing 1 to halt bit 0 is ignored while setup flag is set.
// - With auto clear enabled, a returned STALL clears that halt bit.
// - Bulk OUT one requests DMA while any side holds received data.
// - Bulk IN two requests DMA while any side is not full.
// - DMA requests serve endpoint one and two data registers only.
// - A flush leaves the endpoint interrupt flag untouched.
// - Flush of endpoint two clears both sides; endpoint one selected side.
module ufd_endpoint_housekeeping
    import ufd_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    // AXI4-Lite write data
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    // AXI4-Lite read data
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // USB protocol engine side
    input  wire logic        setup_received_flag,
    input  wire logic        setup_request_decoded,
    input  wire logic [3:0]  stall_returned,
    output logic [3:0]       endpoint_halt_bits,
    // FIFO clear strobes to the endpoint FIFOs
    output logic             control_in_flush,
    output logic             control_out_flush,
    output logic             bulk_out_one_flush,
    output logic             bulk_in_two_flush,
    output logic             control_in_flush_busy,
    output logic             bulk_in_two_flush_busy,
    // FIFO side state for DMA
    input  wire logic [1:0]  bulk_out_one_side_valid,
    input  wire logic [1:0]  bulk_in_two_side_full,
    // Requests to the dma_controller
    output logic             dma_req_bulk_out_one,
    output logic             dma_req_bulk_in_two
);
    logic        aw_held;
    logic        w_held;
    logic [3:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        wr_fire;
    logic        wr_low;
    logic [3:0]  flush_start;
    logic [3:0]  flush_pulse;
    logic [3:0]  flush_busy;
    logic [3:0]  next_halt;
    logic [1:0]  endpoint_dma_request_enable;
    logic        auto_halt_clear_enable;
    logic [3:0]  rd_addr;
    logic        hwr_halt;

    function automatic logic known_offset(input logic [3:0] off);
        known_offset = (off == UFD_OFF_FLUSH) || (off == UFD_OFF_HALT)
                    || (off == UFD_OFF_DMA)   || (off == UFD_OFF_CTRL);
    endfunction : known_offset

    // Address and data may arrive in either order; each is held until both are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 4'h0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= {s_axi_awaddr[3:2], 2'b00};
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    // All fields sit in byte lane 0
    assign wr_low  = wr_fire && w_strb[0];
    assign hwr_halt = wr_low && (aw_addr == UFD_OFF_HALT);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= UFD_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= known_offset(aw_addr) ? UFD_RESP_OKAY : UFD_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // One-shot triggers: nothing is stored but the running clear itself
    always_comb begin
        flush_start = 4'h0;
        if (wr_low && (aw_addr == UFD_OFF_FLUSH)) begin
            flush_start[0] = w_data[UFD_FLUSH_CONTROL_IN_BIT];
            flush_start[1] = w_data[UFD_FLUSH_CONTROL_OUT_BIT];
            flush_start[2] = w_data[UFD_FLUSH_BULK_OUT_ONE_BIT];
            flush_start[3] = w_data[UFD_FLUSH_BULK_IN_TWO_BIT];
        end
    end

    for (genvar i = 0; i < UFD_NUM_FLUSH; i++) begin : g_flush
        ufd_flush_timer u_timer (
            .aclk        (aclk),
            .aresetn     (aresetn),
            .start       (flush_start[i]),
            .flush_pulse (flush_pulse[i]),
            .busy        (flush_busy[i])
        );
    end

    // Strobes go to the FIFOs only; interrupt flags live elsewhere and are untouched
    // Bulk IN two FIFO clears both sides on its strobe, bulk OUT one only its selected side
    assign control_in_flush       = flush_pulse[0];
    assign control_out_flush      = flush_pulse[1];
    assign bulk_out_one_flush     = flush_pulse[2];
    assign bulk_in_two_flush      = flush_pulse[3];
    assign control_in_flush_busy  = flush_busy[0];
    assign bulk_in_two_flush_busy = flush_busy[3];

    // Hardware clears first; a software write in the same cycle has the last word, except a 1 to bit 0 while setup_received_flag is set
    always_comb begin
        next_halt = endpoint_halt_bits;
        if (setup_request_decoded) begin
            next_halt[UFD_HALT_ZERO_BIT] = 1'b0;
        end
        if (auto_halt_clear_enable) begin
            next_halt = next_halt & ~stall_returned;
        end
        if (hwr_halt) begin
            next_halt[3:1] = w_data[3:1];
            if (!(w_data[UFD_HALT_ZERO_BIT] && setup_received_flag)) begin
                next_halt[UFD_HALT_ZERO_BIT] = w_data[UFD_HALT_ZERO_BIT];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            endpoint_halt_bits <= UFD_HALT_RESET;
        end else begin
            endpoint_halt_bits <= next_halt;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            endpoint_dma_request_enable <= UFD_DMA_RESET;
            auto_halt_clear_enable      <= UFD_AUTO_RESET;
        end else if (wr_low) begin
            if (aw_addr == UFD_OFF_DMA) begin
                endpoint_dma_request_enable <= w_data[1:0];
            end
            if (aw_addr == UFD_OFF_CTRL) begin
                auto_halt_clear_enable <= w_data[UFD_CTRL_AUTO_HALT_CLEAR_BIT];
            end
        end
    end

    // Only the endpoint one and two data registers have a DMA path
    ufd_dma_request u_dma (
        .aclk                    (aclk),
        .aresetn                 (aresetn),
        .dma_enable              (endpoint_dma_request_enable),
        .bulk_out_one_side_valid (bulk_out_one_side_valid),
        .bulk_in_two_side_full   (bulk_in_two_side_full),
        .dma_req_bulk_out_one    (dma_req_bulk_out_one),
        .dma_req_bulk_in_two     (dma_req_bulk_in_two)
    );

    // Read channel: one read in flight, data one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= UFD_RESP_OKAY;
            rd_addr      <= 4'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            rd_addr      <= {s_axi_araddr[3:2], 2'b00};
            s_axi_rresp  <= known_offset({s_axi_araddr[3:2], 2'b00})
                            ? UFD_RESP_OKAY : UFD_RESP_SLVERR;
            s_axi_rdata  <= 32'h0000_0000;
            case ({s_axi_araddr[3:2], 2'b00})
                UFD_OFF_FLUSH: begin
                    s_axi_rdata[UFD_FLUSH_BULK_IN_TWO_BIT] <= flush_busy[3];
                    s_axi_rdata[UFD_FLUSH_CONTROL_IN_BIT]  <= flush_busy[0];
                end
                UFD_OFF_HALT: begin
                    s_axi_rdata[3:0] <= endpoint_halt_bits;
                end
                UFD_OFF_DMA: begin
                    s_axi_rdata[1:0] <= endpoint_dma_request_enable;
                end
                UFD_OFF_CTRL: begin
                    s_axi_rdata[UFD_CTRL_AUTO_HALT_CLEAR_BIT] <= auto_halt_clear_enable;
                end
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Checks
    localparam int FLUSH_SPAN = UFD_FLUSH_CYCLES + 1;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic wr_flush;
    assign wr_flush = wr_low && (aw_addr == UFD_OFF_FLUSH);

    property p_two_flush_starts;
        wr_flush && w_data[UFD_FLUSH_BULK_IN_TWO_BIT]
            |=> bulk_in_two_flush && bulk_in_two_flush_busy;
    endproperty
    a_two_flush_starts: assert property (p_two_flush_starts)
        else $error("bulk in two flush did not start");

    property p_two_busy_ends;
        $rose(bulk_in_two_flush_busy) && !flush_start[3]
            |-> ##[1:FLUSH_SPAN] !bulk_in_two_flush_busy;
    endproperty
    a_two_busy_ends: assert property (p_two_busy_ends)
        else $error("bulk in two busy did not clear");

    property p_one_zero_write_idle;
        wr_flush && !w_data[UFD_FLUSH_BULK_OUT_ONE_BIT] |=> !bulk_out_one_flush;
    endproperty
    a_one_zero_write_idle: assert property (p_one_zero_write_idle)
        else $error("bulk out one flushed on a zero write");

    property p_ctrl_out_flush;
        wr_flush && w_data[UFD_FLUSH_CONTROL_OUT_BIT] |=> control_out_flush ##1 !control_out_flush
            or (wr_flush && w_data[UFD_FLUSH_CONTROL_OUT_BIT]);
    endproperty
    a_ctrl_out_flush: assert property (p_ctrl_out_flush)
        else $error("control out flush was not a single pulse");

    property p_ctrl_in_busy;
        wr_flush && w_data[UFD_FLUSH_CONTROL_IN_BIT]
            |=> control_in_flush && control_in_flush_busy;
    endproperty
    a_ctrl_in_busy: assert property (p_ctrl_in_busy)
        else $error("control in flush busy missing");

    property p_halt_set;
        hwr_halt && w_data[2] |=> endpoint_halt_bits[2];
    endproperty
    a_halt_set: assert property (p_halt_set)
        else $error("halt bit two not set by write");

    property p_halt_read_upper;
        s_axi_rvalid && rd_addr == UFD_OFF_HALT |-> s_axi_rdata[31:4] == 28'h0;
    endproperty
    a_halt_read_upper: assert property (p_halt_read_upper)
        else $error("halt register upper bits not zero");

    property p_setup_clears;
        setup_request_decoded && !hwr_halt |=> !endpoint_halt_bits[0];
    endproperty
    a_setup_clears: assert property (p_setup_clears)
        else $error("endpoint zero halt survived a setup");

    property p_setup_blocks;
        hwr_halt && w_data[0] && setup_received_flag && !endpoint_halt_bits[0]
            |=> !endpoint_halt_bits[0];
    endproperty
    a_setup_blocks: assert property (p_setup_blocks)
        else $error("endpoint zero halt set during setup");

    property p_auto_clear;
        auto_halt_clear_enable && stall_returned[1] && !hwr_halt |=> !endpoint_halt_bits[1];
    endproperty
    a_auto_clear: assert property (p_auto_clear)
        else $error("auto clear missed endpoint one");

    property p_dma_one;
        endpoint_dma_request_enable[0] && (|bulk_out_one_side_valid) |=> dma_req_bulk_out_one;
    endproperty
    a_dma_one: assert property (p_dma_one)
        else $error("bulk out one dma request missing");

    property p_dma_two;
        endpoint_dma_request_enable[1] && !(&bulk_in_two_side_full) |=> dma_req_bulk_in_two;
    endproperty
    a_dma_two: assert property (p_dma_two)
        else $error("bulk in two dma request missing");

    property p_dma_off;
        !endpoint_dma_request_enable[1] && !endpoint_dma_request_enable[0]
            |=> !dma_req_bulk_in_two && !dma_req_bulk_out_one;
    endproperty
    a_dma_off: assert property (p_dma_off)
        else $error("dma request while disabled");

    c_two_flush: cover property (wr_flush && w_data[5] ##1 bulk_in_two_flush_busy[*3]);
    c_auto_clear: cover property (auto_halt_clear_enable && stall_returned != 4'h0);
    c_dma_both: cover property (dma_req_bulk_out_one && dma_req_bulk_in_two);
endmodule : ufd_endpoint_housekeeping

// ==== bench/ufd_far_side_model.sv ====
// Far side model: host tokens and endpoint FIFO side state
`timescale 1ns/1ps
module ufd_far_side_model
    import ufd_pkg::*;
(
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Commands from the bench
    input  wire logic [3:0] token,
    input  wire logic       load,
    input  wire logic [1:0] load_valid,
    input  wire logic [1:0] load_full,
    // From the block
    input  wire logic [3:0] endpoint_halt_bits,
    input  wire logic       bulk_out_one_flush,
    input  wire logic       bulk_in_two_flush,
    // To the block
    output logic [3:0]      stall_returned,
    output logic [1:0]      bulk_out_one_side_valid,
    output logic [1:0]      bulk_in_two_side_full
);
    // A token to a halted endpoint gets STALL, one-cycle pulse per endpoint
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stall_returned <= 4'h0;
        end else begin
            stall_returned <= token & endpoint_halt_bits;
        end
    end

    // Endpoint one always has side 0 selected here
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bulk_out_one_side_valid <= 2'h0;
            bulk_in_two_side_full   <= 2'h0;
        end else if (load) begin
            bulk_out_one_side_valid <= load_valid;
            bulk_in_two_side_full   <= load_full;
        end else begin
            if (bulk_out_one_flush) bulk_out_one_side_valid[0] <= 1'b0;
            if (bulk_in_two_flush) bulk_in_two_side_full <= 2'h0;
        end
    end
endmodule : ufd_far_side_model

// ==== bench/tb.sv ====
// Self-checking bench for the endpoint housekeeping block
`timescale 1ns/1ps
module tb
    import ufd_pkg::*;
;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp, bulk_out_one_side_valid, bulk_in_two_side_full;
    logic [1:0]  load_valid, load_full;
    logic [3:0]  stall_returned, endpoint_halt_bits, token;
    logic setup_received_flag, setup_request_decoded, load, control_in_flush, control_out_flush;
    logic bulk_out_one_flush, bulk_in_two_flush, control_in_flush_busy, bulk_in_two_flush_busy;
    logic dma_req_bulk_out_one, dma_req_bulk_in_two;
    int n_mismatch, checked, cycles, pc[4], bc0, bc5;

    ufd_endpoint_housekeeping ufd_endpoint_housekeeping_inst (
        .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0),
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_bvalid,
        .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
        .setup_received_flag, .setup_request_decoded, .stall_returned, .endpoint_halt_bits,
        .control_in_flush, .control_out_flush, .bulk_out_one_flush, .bulk_in_two_flush,
        .control_in_flush_busy, .bulk_in_two_flush_busy, .bulk_out_one_side_valid,
        .bulk_in_two_side_full, .dma_req_bulk_out_one, .dma_req_bulk_in_two);

    ufd_far_side_model ufd_far_side_model_inst (
        .aclk, .aresetn, .token, .load, .load_valid, .load_full, .endpoint_halt_bits,
        .bulk_out_one_flush, .bulk_in_two_flush, .stall_returned, .bulk_out_one_side_valid,
        .bulk_in_two_side_full);

    initial aclk = 1'b0;
    always #25 aclk = ~aclk;

    task automatic report_and_stop();
        $display("mismatches=%0d checks=%0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    // Pulse and busy-cycle tallies; a hang ends the run
    always @(posedge aclk) begin
        cycles++;
        if (control_in_flush === 1'b1) pc[0]++;
        if (control_out_flush === 1'b1) pc[1]++;
        if (bulk_out_one_flush === 1'b1) pc[2]++;
        if (bulk_in_two_flush === 1'b1) pc[3]++;
        if (control_in_flush_busy === 1'b1) bc0++;
        if (bulk_in_two_flush_busy === 1'b1) bc5++;
        if (cycles > 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr  <= a;
        s_axi_wvalid  <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_bready  <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && s_axi_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready === 1'b1) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(UFD_RESP_OKAY));
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        @(posedge aclk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr  <= a;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, exp);
        chk(32'(s_axi_rresp), 32'(UFD_RESP_OKAY));
    endtask : rd

    task automatic ld(input logic [1:0] v, input logic [1:0] f);
        @(posedge aclk);
        load <= 1'b1;
        load_valid <= v;
        load_full <= f;
        @(posedge aclk);
        load <= 1'b0;
        repeat (3) @(posedge aclk);
        #1;
    endtask : ld

    task automatic tok(input logic [3:0] t, input logic [3:0] exp);
        @(posedge aclk);
        token <= t;
        @(posedge aclk);
        token <= 4'h0;
        #1;
        chk(32'(stall_returned), 32'(exp));
        repeat (3) @(posedge aclk);
    endtask : tok

    task automatic t_reset();
        for (int i = 0; i < 4; i++) rd(32'(4 * i), 32'h0);
        chk(32'(endpoint_halt_bits), 32'h0);
    endtask : t_reset

    task automatic t_flush();
        int bits[4] = '{0, 1, 4, 5};
        int snap[4];
        int b0, b5;
        ld(2'b11, 2'b11);
        for (int i = 0; i < 5; i++) begin
            snap = pc;
            b0 = bc0;
            b5 = bc5;
            // Last pass writes zero and must start nothing
            wr(32'(UFD_OFF_FLUSH), (i < 4) ? 32'h1 << bits[i] : 32'h0);
            rd(32'(UFD_OFF_FLUSH), (i == 3) ? 32'h20 : 32'(i == 0));
            repeat (UFD_FLUSH_CYCLES + 6) @(posedge aclk);
            for (int j = 0; j < 4; j++) chk(32'(pc[j] - snap[j]), 32'(i == j));
            chk(32'(bc0 - b0), (i == 0) ? 32'(UFD_FLUSH_CYCLES) : 32'h0);
            chk(32'(bc5 - b5), (i == 3) ? 32'(UFD_FLUSH_CYCLES) : 32'h0);
            rd(32'(UFD_OFF_FLUSH), 32'h0);
        end
        chk(32'({bulk_out_one_side_valid, bulk_in_two_side_full}), 32'h8);
    endtask : t_flush

    task automatic t_halt();
        wr(32'(UFD_OFF_HALT), 32'hffff_ffff);
        rd(32'(UFD_OFF_HALT), 32'hf);
        tok(4'h4, 4'h4);
        rd(32'(UFD_OFF_HALT), 32'hf);
        wr(32'(UFD_OFF_HALT), 32'h0);
        wr(32'(UFD_OFF_CTRL), 32'h2);
        wr(32'(UFD_OFF_HALT), 32'hf);
        tok(4'ha, 4'ha);
        rd(32'(UFD_OFF_HALT), 32'h5);
        wr(32'(UFD_OFF_CTRL), 32'h0);
        @(posedge aclk);
        setup_request_decoded <= 1'b1;
        @(posedge aclk);
        setup_request_decoded <= 1'b0;
        rd(32'(UFD_OFF_HALT), 32'h4);
        setup_received_flag <= 1'b1;
        wr(32'(UFD_OFF_HALT), 32'h5);
        rd(32'(UFD_OFF_HALT), 32'h4);
        setup_received_flag <= 1'b0;
        wr(32'(UFD_OFF_HALT), 32'h1);
        rd(32'(UFD_OFF_HALT), 32'h1);
    endtask : t_halt

    task automatic t_dma();
        ld(2'b01, 2'b01);
        chk(32'({dma_req_bulk_out_one, dma_req_bulk_in_two}), 32'h0);
        wr(32'(UFD_OFF_DMA), 32'hffff_ffff);
        rd(32'(UFD_OFF_DMA), 32'h3);
        ld(2'b01, 2'b01);
        chk(32'({dma_req_bulk_out_one, dma_req_bulk_in_two}), 32'h3);
        ld(2'b00, 2'b11);
        chk(32'({dma_req_bulk_out_one, dma_req_bulk_in_two}), 32'h0);
        wr(32'(UFD_OFF_DMA), 32'h1);
        ld(2'b10, 2'b10);
        chk(32'({dma_req_bulk_out_one, dma_req_bulk_in_two}), 32'h2);
    endtask : t_dma

    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
        {setup_received_flag, setup_request_decoded, load, token} = 7'h0;
        {load_valid, load_full} = 4'h0;
        aresetn = 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_flush();
        t_halt();
        t_dma();
        report_and_stop();
    end
endmodule : tb
